// File: atf_task_file.sv
/*
  Task file data registers of a removable storage card, plus the data
  FIFOs between the host data port and the card buffer.
  Assumes host pins are synchronous-sampled, strobes are held for at
  least three clocks, and a command engine drives the event inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "atf_map.svh"

// ****************************************************************
// data fifo
// ****************************************************************
module atf_fifo #(
  parameter int WIDTH = `ATF_FIFO_WIDTH,
  parameter int DEPTH = `ATF_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // flags are flops so both handshakes see clean levels
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign cnt_next   = cnt_reg + CW'(push) - CW'(pop);
  assign out_data_o = mem_reg[rd_ptr_reg];

  // storage, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers, fill level and handshake flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      cnt_reg     <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      cnt_reg     <= cnt_next;
      in_ready_o  <= (cnt_next != CW'(DEPTH));
      out_valid_o <= (cnt_next != '0);
    end
  end
endmodule : atf_fifo

// ****************************************************************
// task file top
// ****************************************************************
module atf_task_file #(
  parameter int FIFO_DEPTH = `ATF_FIFO_DEPTH
) (
  input  wire logic               CORE_CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               IDE_MODE_I,
  input  wire logic               IO_CYCLE_I,
  input  wire logic               REG_SEL_N_I,
  input  wire atf_pkg::atf_sel_t  HOST_SEL_I,
  input  wire logic [3:0]         ADDR_I,
  input  wire logic               RD_N_I,
  input  wire logic               WR_N_I,
  input  wire logic [15:0]        DATA_I,
  output logic [15:0]             DATA_O,
  output logic [1:0]              DATA_OE_O,
  output logic                    WIDE_IO_ACK_N_O,
  output logic                    HOST_READY_O,
  input  wire logic               BYTE_MODE_I,
  input  wire logic               LINEAR_ADDRESSING_I,
  input  wire logic               CMD_START_I,
  input  wire logic               CMD_FAIL_I,
  input  wire atf_pkg::atf_err_t  ERR_EVENT_I,
  input  wire logic               SECTOR_DONE_I,
  output logic [7:0]              FEATURE_O,
  output logic [8:0]              XFER_SECTORS_O,
  output atf_pkg::atf_start_t     START_O,
  output logic                    STATUS_ERROR_O,
  output logic [15:0]             BUF_WDATA_O,
  output logic                    BUF_WVALID_O,
  input  wire logic               BUF_WREADY_I,
  input  wire logic [15:0]        BUF_RDATA_I,
  input  wire logic               BUF_RVALID_I,
  output logic                    BUF_RREADY_O
);
  import atf_pkg::*;

  logic [2:0]  rd_sync_reg;
  logic [2:0]  wr_sync_reg;
  logic        rd_rise;
  logic        wr_rise;
  atf_acc_t    acc;
  logic        odd_sel;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  logic        phase_reg;
  logic [7:0]  err_reg;
  logic [7:0]  scnt_reg;
  logic [7:0]  snum_reg;
  logic [7:0]  cyll_reg;
  logic [7:0]  cylh_reg;
  logic [7:0]  hold_lo_reg;
  logic [15:0] wword_reg;
  logic        wpend_reg;
  logic        wf_ready;
  logic [15:0] rf_data;
  logic        rf_valid;
  logic        rf_pop;
  logic        data_acc;
  logic        data_off;

  // map an offset onto the register behind it
  function automatic atf_tgt_t reg_tgt(input logic [3:0] off);
    case (off)
      `ATF_OFF_DATA, `ATF_OFF_DATA_EVEN, `ATF_OFF_DATA_ODD:
        reg_tgt = ATF_DATA;
      `ATF_OFF_ERRF, `ATF_OFF_DUP_ERRF: reg_tgt = ATF_ERRF;
      `ATF_OFF_SCNT: reg_tgt = ATF_SCNT;
      `ATF_OFF_SNUM: reg_tgt = ATF_SNUM;
      `ATF_OFF_CYLL: reg_tgt = ATF_CYLL;
      `ATF_OFF_CYLH: reg_tgt = ATF_CYLH;
      default:       reg_tgt = ATF_NONE;
    endcase
  endfunction : reg_tgt

  // decode the pins into target register and lanes
  function automatic atf_acc_t decode(input atf_sel_t s,
                                      input logic [3:0] a);
    atf_acc_t r;
    r = '{tgt: ATF_NONE, lanes: `ATF_LANE_NONE, fix_odd: 1'b0};
    if (IDE_MODE_I)
    begin
      if (!s.dma_grant_n && s.command_block_select_n &&
          s.control_block_select_n)
        r = '{ATF_DATA, `ATF_LANE_WORD, 1'b0};
      else if (!s.command_block_select_n && s.control_block_select_n &&
               s.dma_grant_n && !a[3])
      begin
        r.tgt   = reg_tgt({1'b0, a[2:0]});
        r.lanes = `ATF_LANE_LO;
        if (r.tgt == ATF_DATA && !BYTE_MODE_I)
          r.lanes = `ATF_LANE_WORD;
      end
    end
    else if (REG_SEL_N_I != IO_CYCLE_I)
    begin
      if (!s.low_byte_select_n && !s.high_byte_select_n)
      begin
        r.tgt   = reg_tgt(a);
        r.lanes = `ATF_LANE_LO;
        if (a == `ATF_OFF_DUP_ERRF)
          r.lanes = `ATF_LANE_HI;
        else if (r.tgt == ATF_DATA || a == `ATF_OFF_ERRF)
        begin
          r.tgt   = ATF_DATA;
          r.lanes = `ATF_LANE_WORD;
        end
      end
      else if (!s.low_byte_select_n)
      begin
        r.tgt     = reg_tgt(a);
        r.lanes   = `ATF_LANE_LO;
        r.fix_odd = (a == `ATF_OFF_DATA_ODD);
      end
      else if (!s.high_byte_select_n)
      begin
        // odd register through the even address, upper lane
        r.lanes = `ATF_LANE_HI;
        if (a == `ATF_OFF_DATA)
          r.tgt = ATF_ERRF;
        else if (a[3:1] == 3'b100)
        begin
          r.tgt     = ATF_DATA;
          r.fix_odd = 1'b1;
        end
        else if (!IO_CYCLE_I)
          r.tgt = reg_tgt(a | 4'h1);
        if (r.tgt == ATF_NONE) r.lanes = `ATF_LANE_NONE;
      end
    end
    decode = r;
  endfunction : decode

  // ****************************************************************
  // strobe synchronisers and access decode
  // ****************************************************************

  // strobes cross in through two flops; stage 0 feeds stage 1 only
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rd_sync_reg <= 3'b000;
      wr_sync_reg <= 3'b000;
    end
    else
    begin
      rd_sync_reg <= {rd_sync_reg[1:0], ~RD_N_I};
      wr_sync_reg <= {wr_sync_reg[1:0], ~WR_N_I};
    end
  end

  // address and data are stable by the time the edge is seen
  assign rd_rise  = rd_sync_reg[1] & ~rd_sync_reg[2];
  assign wr_rise  = wr_sync_reg[1] & ~wr_sync_reg[2];
  assign odd_sel  = acc.fix_odd | phase_reg;
  assign data_acc = (acc.tgt == ATF_DATA);
  assign wr_byte  = (acc.lanes == `ATF_LANE_HI) ? DATA_I[15:8]
                                                : DATA_I[7:0];
  assign rf_pop   = rd_rise & data_acc & rf_valid &
                    ((acc.lanes == `ATF_LANE_WORD) | odd_sel);
  assign data_off = (ADDR_I == `ATF_OFF_DATA) |
                    (ADDR_I[3:1] == 3'b100);

  // decode reads the mode pins too, so a comb block keeps it current
  always_comb
  begin
    acc = decode(HOST_SEL_I, ADDR_I);
  end

  // byte returned for a narrow read
  always_comb
  begin
    case (acc.tgt)
      ATF_DATA: rd_byte = odd_sel ? rf_data[15:8] : rf_data[7:0];
      ATF_ERRF: rd_byte = err_reg;
      ATF_SCNT: rd_byte = scnt_reg;
      ATF_SNUM: rd_byte = snum_reg;
      ATF_CYLL: rd_byte = cyll_reg;
      ATF_CYLH: rd_byte = cylh_reg;
      default:  rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // host data bus
  // ****************************************************************

  // lanes driven only while an addressed read strobe stands
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      DATA_O    <= 16'h0000;
      DATA_OE_O <= `ATF_LANE_NONE;
    end
    else if (rd_rise && acc.tgt != ATF_NONE)
    begin
      DATA_OE_O <= acc.lanes;
      if (acc.lanes == `ATF_LANE_WORD)
        DATA_O <= rf_data;
      else if (acc.lanes == `ATF_LANE_HI)
        DATA_O <= {rd_byte, 8'h00};
      else
        DATA_O <= {8'h00, rd_byte};
    end
    else if (!rd_sync_reg[1])
      DATA_OE_O <= `ATF_LANE_NONE;
  end

  // 16-bit acknowledge only for the data port in I/O cycles
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      WIDE_IO_ACK_N_O <= 1'b1;
      HOST_READY_O    <= 1'b1;
    end
    else
    begin
      WIDE_IO_ACK_N_O <= ~(IO_CYCLE_I & ~IDE_MODE_I & data_off);
      HOST_READY_O    <= wf_ready & ~wpend_reg;
    end
  end

  // byte order: even then odd, a word resets the order
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      phase_reg <= 1'b0;
    else if ((rd_rise || wr_rise) && data_acc)
      phase_reg <= (acc.lanes != `ATF_LANE_WORD) & ~odd_sel;
  end

  // ****************************************************************
  // data write assembly toward the card buffer
  // ****************************************************************

  // a full fifo holds the word here and drops HOST_READY_O
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      hold_lo_reg <= 8'h00;
      wword_reg   <= 16'h0000;
      wpend_reg   <= 1'b0;
    end
    else
    begin
      if (wpend_reg && wf_ready) wpend_reg <= 1'b0;
      if (wr_rise && data_acc && !wpend_reg)
      begin
        if (acc.lanes == `ATF_LANE_WORD)
        begin
          wword_reg <= DATA_I;
          wpend_reg <= 1'b1;
        end
        else if (!odd_sel)
          hold_lo_reg <= wr_byte;
        else
        begin
          wword_reg <= {wr_byte, hold_lo_reg};
          wpend_reg <= 1'b1;
        end
      end
    end
  end

  atf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (wword_reg),
    .in_valid_i  (wpend_reg),
    .in_ready_o  (wf_ready),
    .out_data_o  (BUF_WDATA_O),
    .out_valid_o (BUF_WVALID_O),
    .out_ready_i (BUF_WREADY_I)
  );

  atf_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (BUF_RDATA_I),
    .in_valid_i  (BUF_RVALID_I),
    .in_ready_o  (BUF_RREADY_O),
    .out_data_o  (rf_data),
    .out_valid_o (rf_valid),
    .out_ready_i (rf_pop)
  );

  // ****************************************************************
  // byte registers
  // ****************************************************************

  // feature value, write only from the host
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      FEATURE_O <= 8'h00;
    else if (wr_rise && acc.tgt == ATF_ERRF)
      FEATURE_O <= wr_byte;
  end

  // start address bytes
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      snum_reg <= 8'h00;
      cyll_reg <= 8'h00;
      cylh_reg <= 8'h00;
    end
    else if (wr_rise)
    begin
      if (acc.tgt == ATF_SNUM) snum_reg <= wr_byte;
      if (acc.tgt == ATF_CYLL) cyll_reg <= wr_byte;
      if (acc.tgt == ATF_CYLH) cylh_reg <= wr_byte;
    end
  end

  // host write wins; each finished sector takes one off
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      scnt_reg <= `ATF_SCNT_RST;
    else if (wr_rise && acc.tgt == ATF_SCNT)
      scnt_reg <= wr_byte;
    else if (SECTOR_DONE_I)
      scnt_reg <= scnt_reg - 8'h01;
  end

  // zero wraps through 255, matching the 256 meaning
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      XFER_SECTORS_O <= {1'b0, `ATF_SCNT_RST};
      START_O        <= '0;
    end
    else
    begin
      XFER_SECTORS_O <= (scnt_reg == 8'h00) ? `ATF_SCNT_FULL
                                            : {1'b0, scnt_reg};
      START_O.linear_addressing_flag <= LINEAR_ADDRESSING_I;
      START_O.value <= {cylh_reg, cyll_reg, snum_reg};
    end
  end

  // ****************************************************************
  // failure detail and status error flag
  // ****************************************************************

  // new events beat the clear at command start
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      err_reg <= 8'h00;
    else
    begin
      if (CMD_START_I) err_reg <= 8'h00;
      if (ERR_EVENT_I.bad_block_flag)
        err_reg[`ATF_ERR_BAD_BLOCK] <= 1'b1;
      if (ERR_EVENT_I.uncorrectable_flag)
        err_reg[`ATF_ERR_UNCORR] <= 1'b1;
      if (ERR_EVENT_I.sector_id_missing_flag)
        err_reg[`ATF_ERR_ID_MISS] <= 1'b1;
      if (ERR_EVENT_I.command_aborted_flag)
        err_reg[`ATF_ERR_ABORTED] <= 1'b1;
      if (ERR_EVENT_I.general_error_flag)
        err_reg[`ATF_ERR_GENERAL] <= 1'b1;
    end
  end

  // set on failure, cleared by the next command; set wins
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      STATUS_ERROR_O <= 1'b0;
    else if (CMD_FAIL_I)
      STATUS_ERROR_O <= 1'b1;
    else if (CMD_START_I)
      STATUS_ERROR_O <= 1'b0;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_err_zero_bits;
    (err_reg & `ATF_ERR_ZERO_MASK) == 8'h00;
  endproperty
  a_err_zero_bits: assert property (p_err_zero_bits)
    else $error("reserved error bits set");

  property p_abort_bit;
    ERR_EVENT_I.command_aborted_flag |=> err_reg[`ATF_ERR_ABORTED];
  endproperty
  a_abort_bit: assert property (p_abort_bit)
    else $error("abort event not recorded");

  property p_zero_is_256;
    scnt_reg == 8'h00 |=> XFER_SECTORS_O == `ATF_SCNT_FULL;
  endproperty
  a_zero_is_256: assert property (p_zero_is_256)
    else $error("zero count not reported as 256");

  property p_count_down;
    SECTOR_DONE_I && !(wr_rise && acc.tgt == ATF_SCNT)
      |=> scnt_reg == $past(scnt_reg) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("sector count did not step down");

  property p_flag_clear;
    CMD_START_I && !CMD_FAIL_I |=> !STATUS_ERROR_O ##1 1'b1;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("error flag not cleared by command");

  property p_flag_set;
    CMD_FAIL_I |=> STATUS_ERROR_O;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("error flag not set on failure");

  property p_drive_in_read;
    DATA_OE_O != `ATF_LANE_NONE |-> rd_sync_reg[2] || rd_sync_reg[1];
  endproperty
  a_drive_in_read: assert property (p_drive_in_read)
    else $error("data driven outside a read");

  property p_feature_sync;
    $changed(FEATURE_O) |-> $past(wr_rise);
  endproperty
  a_feature_sync: assert property (p_feature_sync)
    else $error("feature changed without strobe");

  property p_release;
    !rd_sync_reg[1] && !rd_sync_reg[2] |=> DATA_OE_O == `ATF_LANE_NONE;
  endproperty
  a_release: assert property (p_release)
    else $error("bus not released after read");

endmodule : atf_task_file

`default_nettype wire

// File: atf_map.svh
/*
  Offsets, field positions, reset values and lane codes of the task file
  block. Assumes inclusion by the design file only.
*/
`ifndef ATF_MAP_SVH
`define ATF_MAP_SVH

// ****************************************************************
// register offsets as seen on the host address lines
// ****************************************************************
`define ATF_OFF_DATA      4'h0
`define ATF_OFF_ERRF      4'h1
`define ATF_OFF_SCNT      4'h2
`define ATF_OFF_SNUM      4'h3
`define ATF_OFF_CYLL      4'h4
`define ATF_OFF_CYLH      4'h5
`define ATF_OFF_DATA_EVEN 4'h8
`define ATF_OFF_DATA_ODD  4'h9
`define ATF_OFF_DUP_ERRF  4'hD

// ****************************************************************
// failure detail bit positions
// ****************************************************************
`define ATF_ERR_BAD_BLOCK 7
`define ATF_ERR_UNCORR    6
`define ATF_ERR_ID_MISS   4
`define ATF_ERR_ABORTED   2
`define ATF_ERR_GENERAL   0
`define ATF_ERR_ZERO_MASK 8'h2A

// ****************************************************************
// reset values and counts
// ****************************************************************
`define ATF_SCNT_RST      8'h01
`define ATF_SCNT_FULL     9'h100
`define ATF_FIFO_DEPTH    8
`define ATF_FIFO_WIDTH    16

// ****************************************************************
// data lane codes: bit 0 low lane, bit 1 high lane
// ****************************************************************
`define ATF_LANE_NONE     2'b00
`define ATF_LANE_LO       2'b01
`define ATF_LANE_HI       2'b10
`define ATF_LANE_WORD     2'b11

`endif

// File: atf_pkg.sv
/*
  Types shared by the task file block: register targets, decoded host
  access, error events, host selects and start address.
  Assumes atf_map.svh is on the include path.
*/
`default_nettype none

package atf_pkg;

  // register that a host access lands on
  typedef enum logic [2:0] {
    ATF_NONE, ATF_DATA, ATF_ERRF, ATF_SCNT, ATF_SNUM, ATF_CYLL, ATF_CYLH
  } atf_tgt_t;

  typedef struct packed {
    atf_tgt_t    tgt;
    logic [1:0]  lanes;
    logic        fix_odd;
  } atf_acc_t;

  // one-cycle error events from the command engine
  typedef struct packed {
    logic bad_block_flag;
    logic uncorrectable_flag;
    logic sector_id_missing_flag;
    logic command_aborted_flag;
    logic general_error_flag;
  } atf_err_t;

  // host selects, all active low
  typedef struct packed {
    logic low_byte_select_n;
    logic high_byte_select_n;
    logic command_block_select_n;
    logic control_block_select_n;
    logic dma_grant_n;
  } atf_sel_t;

  typedef struct packed {
    logic        linear_addressing_flag;
    logic [23:0] value;
  } atf_start_t;

endpackage : atf_pkg

`default_nettype wire

// File: atf_host_model.sv
/* host bus model: one strobe cycle per call on the task file pins.
   assumes the bench owns clock and reset. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host strobe cycles
// ****************************************
module atf_host_model (
  input  wire logic          clk_i,
  input  wire logic          io_i,
  output atf_pkg::atf_sel_t  sel_o,
  output logic               reg_sel_n_o,
  output logic [3:0]         addr_o,
  output logic               rd_n_o,
  output logic               wr_n_o,
  output logic [15:0]        data_o,
  input  wire logic [15:0]   rdata_i,
  input  wire logic [1:0]    oe_i
);
  import atf_pkg::*;
  // register select follows the cycle kind: low for I/O, high memory
  assign reg_sel_n_o = ~io_i;
  // idle bus: nothing selected, no strobe
  initial
  begin
    sel_o       = 5'h1F;
    addr_o      = 4'h0;
    rd_n_o      = 1'b1;
    wr_n_o      = 1'b1;
    data_o      = 16'h0000;
  end
  // strobe held 4 clocks, then 4 idle clocks keep the spacing legal
  task automatic cyc(input logic w, input logic [3:0] a,
                     input logic [4:0] s, input logic [15:0] d,
                     output logic [15:0] q, output logic [1:0] oe);
    @(posedge clk_i);
    sel_o  <= s;
    addr_o <= a;
    data_o <= d;
    rd_n_o <= w;
    wr_n_o <= !w;
    repeat (4) @(posedge clk_i);
    q  = rdata_i;
    oe = oe_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    sel_o  <= 5'h1F;
    // released lines must not keep showing the old value
    data_o <= ~d;
    repeat (4) @(posedge clk_i);
  endtask : cyc
endmodule : atf_host_model
`default_nettype wire

// File: atf_task_file_bench.sv
/* self-checking bench of the task file block.
   assumes the host model drives the register pins. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module atf_task_file_bench;
  import atf_pkg::*;
  localparam logic [4:0] LO = 5'b01111;
  localparam logic [4:0] HI = 5'b10111;
  localparam logic [4:0] WD = 5'b00111;
  localparam logic [4:0] PIO = 5'b11011;
  localparam logic [4:0] DMA = 5'b11110;
  logic clk, rst, ide, io, bmode, lin, start, fail, done;
  logic rsel_n, rd_n, wr_n, wrdy, rval, hrdy, wval, rrdy, serr, ack_n;
  logic [3:0]  addr;
  logic [15:0] din, dout, wdat, rdat, q;
  logic [1:0]  oe, doe;
  logic [7:0]  feat;
  logic [8:0]  xfer;
  atf_sel_t    sel;
  atf_err_t    err;
  atf_start_t  st;
  int error_cnt, check_count;
  atf_host_model atf_host_model_inst (.clk_i(clk), .io_i(io), .sel_o(sel),
    .reg_sel_n_o(rsel_n), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .data_o(din), .rdata_i(dout), .oe_i(doe));
  atf_task_file atf_task_file_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .IDE_MODE_I(ide), .IO_CYCLE_I(io), .REG_SEL_N_I(rsel_n),
    .HOST_SEL_I(sel), .ADDR_I(addr), .RD_N_I(rd_n), .WR_N_I(wr_n),
    .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe), .WIDE_IO_ACK_N_O(ack_n),
    .HOST_READY_O(hrdy), .BYTE_MODE_I(bmode), .LINEAR_ADDRESSING_I(lin),
    .CMD_START_I(start), .CMD_FAIL_I(fail), .ERR_EVENT_I(err),
    .SECTOR_DONE_I(done), .FEATURE_O(feat), .XFER_SECTORS_O(xfer),
    .START_O(st), .STATUS_ERROR_O(serr), .BUF_WDATA_O(wdat),
    .BUF_WVALID_O(wval), .BUF_WREADY_I(wrdy), .BUF_RDATA_I(rdat),
    .BUF_RVALID_I(rval), .BUF_RREADY_O(rrdy));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic ac(input logic w, input logic [3:0] a,
                    input logic [4:0] s, input logic [15:0] d);
    atf_host_model_inst.cyc(w, a, s, d, q, oe);
  endtask : ac
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic t_reset();
    ac(0, 4'h2, LO, 16'h0);
    chk("count", 32'h0001, q);
    chk("count oe", 32'h1, oe);
  endtask : t_reset
  task automatic t_addr();
    ac(1, 4'h3, LO, 16'h0012);
    ac(1, 4'h4, LO, 16'h0034);
    ac(1, 4'h5, LO, 16'h0056);
    chk("start", 32'h0156_3412, st);
    ac(0, 4'h2, HI, 16'h0);
    chk("alias", 32'h6_1200, {ack_n, oe, q});
  endtask : t_addr
  task automatic t_count();
    ac(1, 4'h2, LO, 16'h0002);
    repeat (2)
    begin
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk("sectors", 32'h0100, xfer);
    ac(0, 4'h2, LO, 16'h0);
    chk("count", 32'h0000, q);
  endtask : t_count
  task automatic t_err();
    @(posedge clk);
    err  <= 5'h1F;
    fail <= 1'b1;
    @(posedge clk);
    err  <= 5'h00;
    fail <= 1'b0;
    ac(0, 4'h1, LO, 16'h0);
    chk("error", 32'h00D5, q);
    chk("status", 32'h1, serr);
    ac(0, 4'hD, LO, 16'h0);
    chk("dup error", 32'h00D5, q);
    ac(0, 4'h0, HI, 16'h0);
    chk("upper error", 32'h00D5, q[15:8]);
    chk("upper oe", 32'h2, oe);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    ac(0, 4'h1, LO, 16'h0);
    chk("cleared", 32'h0, {serr, q});
  endtask : t_err
  task automatic t_feat();
    ac(1, 4'h1, LO, 16'h00A5);
    chk("feature", 32'h00A5, feat);
    ac(1, 4'h0, HI, 16'h3C00);
    chk("upper feature", 32'h003C, feat);
  endtask : t_feat
  task automatic t_wfifo();
    int n;
    // nine words: eight fill the fifo, one stays pending
    for (int i = 0; i < 9; i++)
      ac(1, (i == 1) ? 4'h1 : 4'h0, WD, 16'h1000 + 16'(i));
    chk("refused", 32'h0, hrdy);
    for (int i = 0; i < 9; i++)
    begin
      n = 0;
      while (wval !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      chk("word", 32'h1000 + i, wdat);
      @(posedge clk) wrdy <= 1'b1;
      @(posedge clk) wrdy <= 1'b0;
      // let the popped head settle before the next look
      @(posedge clk);
    end
  endtask : t_wfifo
  task automatic t_rfifo();
    @(posedge clk);
    rdat <= 16'hBEEF;
    rval <= 1'b1;
    @(posedge clk) rval <= 1'b0;
    ac(0, 4'h8, WD, 16'h0);
    chk("read word", 32'hBEEF, q);
    chk("read oe", 32'h3, oe);
  endtask : t_rfifo
  task automatic t_io();
    @(posedge clk) io <= 1'b1;
    ac(0, 4'h2, HI, 16'h0);
    chk("io alias refused", 32'h4, {ack_n, oe});
    ac(0, 4'h0, HI, 16'h0);
    chk("io upper error", 32'h2, {ack_n, oe});
    @(posedge clk) io <= 1'b0;
  endtask : t_io
  task automatic t_ide();
    @(posedge clk) {ide, rval, rdat} <= {2'b11, 16'h1234};
    @(posedge clk) rdat <= 16'h5678;
    @(posedge clk) rval <= 1'b0;
    chk("fill ready", 32'h1, rrdy);
    ac(0, 4'h0, PIO, 16'h0);
    chk("pio word", 32'h3_1234, {oe, q});
    ac(0, 4'h7, DMA, 16'h0);
    chk("dma word", 32'h3_5678, {oe, q});
    ac(0, 4'h3, PIO, 16'h0);
    chk("ide byte reg", 32'h1_0012, {oe, q});
    @(posedge clk) bmode <= 1'b1;
    ac(1, 4'h0, PIO, 16'h0011);
    ac(1, 4'h0, PIO, 16'h0022);
    chk("byte pair", 32'h1_2211, {wval, wdat});
    ac(0, 4'h0, PIO, 16'h0);
    chk("byte oe", 32'h1, oe);
    @(posedge clk) {ide, bmode} <= 2'b00;
  endtask : t_ide
  // watchdog against a hung handshake
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    {rst, ide, io, bmode, lin, start, fail, done} = 8'h88;
    {wrdy, rval, err, rdat} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_addr();
    t_count();
    t_err();
    t_feat();
    t_wfifo();
    t_rfifo();
    t_io();
    t_ide();
    complete_run();
  end
endmodule : atf_task_file_bench
`default_nettype wire
